// [logic/timer_pwm_dual_capture.v]
// Purpose: 16-bit timer with complementary PWM with deadband, capture and capture with restart.
// Assumes: APB slave on pclk, inputs synchronous to pclk, pclk_en freezes all state.
// Notes: Interrupt request is a one-cycle pulse per qualifying event.
// Behaviour
// - Mode code 1000 selects complementary PWM.
// - Count equals match value toggles both outputs.
// - Reload: interrupt, count to 0001h, restore polarity level.
// - Polarity one: start high, low at match.
// - Polarity zero: start low, high at match.
// - Complement output inverts primary except deadband.
// - Deadband gap of 0 to 128 ticks.
// - Deadband and clock select in control zero.
// - Mode top bit lives in control zero.
// - Written start count affects first pass only.
// - Mode 0100 captures count on input edge.
// - Polarity bit selects capture edge.
// - Capture: interrupt, set flag, keep counting.
// - Capture reload: interrupt, clear flag, continue.
// - Mode 1001 capture stores, interrupts, restarts count.
// - Restart mode reload: interrupt, restart, clear flag.
// - Interrupt source field restricts capture interrupts.
// - Input zero from pin or event routing.
`include "timer_consts.vh"
`default_nettype none
module timer_pwm_dual_capture (
  // Clock, enable and reset.
  input wire pclk,
  input wire pclk_en,
  input wire presetn,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Timer clock sources and input zero.
  input wire alt_tick,
  input wire pin_input,
  input wire event_input,
  // Outputs.
  output reg pwm_primary_output,
  output reg pwm_complement_output,
  output reg timer_irq
);
  reg [15:0] ctl0_reg;
  reg [8:0] ctl1_reg;
  reg [15:0] count_reg;
  reg [15:0] reload_reg;
  reg [15:0] match_capture_value_reg;
  reg capture_cause_flag_reg;
  reg [6:0] pre_reg;
  reg in_prev_reg;
  reg pwm_state_reg;
  reg [7:0] db_cnt_reg;
  reg run_reg;
  wire [3:0] operating_mode_select;
  wire output_edge_polarity;
  wire [1:0] interrupt_source_config;
  wire [7:0] deadband;
  wire enable;
  wire [2:0] pre_sel;
  wire [6:0] pre_limit;
  wire base_tick;
  wire tick;
  wire timer_in;
  wire edge_det;
  wire is_pwm;
  wire is_cap;
  wire is_caprs;
  wire reload_hit;
  wire match_hit;
  wire cap_evt;
  wire wr;
  wire rd;
  wire mapped;
  reg [15:0] count_next;
  reg pwm_state_next;
  reg [7:0] db_cnt_next;
  reg primary_next;
  reg complement_next;
  reg [31:0] rdata_next;
  wire [7:0] db_load;

  assign wr = psel & penable & pwrite & pclk_en;
  assign rd = psel & ~pwrite;
  assign pready = 1'b1;
  assign mapped = (paddr == `OFS_CTL0) | (paddr == `OFS_CTL1) | (paddr == `OFS_COUNT) |
    (paddr == `OFS_RELOAD) | (paddr == `OFS_MATCH) | (paddr == `OFS_STATUS);
  assign pslverr = psel & penable & ~mapped;

  // The top bit of the mode code sits in control zero.
  assign operating_mode_select = {ctl0_reg[`CTL0_MODE3], ctl1_reg[`CTL1_MODE_HI:`CTL1_MODE_LO]};
  assign output_edge_polarity = ctl1_reg[`CTL1_POL];
  assign interrupt_source_config = ctl0_reg[`CTL0_ICFG_HI:`CTL0_ICFG_LO];
  assign deadband = ctl0_reg[`CTL0_DB_HI:`CTL0_DB_LO];
  assign enable = ctl1_reg[`CTL1_EN];
  assign pre_sel = ctl1_reg[`CTL1_PRE_HI:`CTL1_PRE_LO];
  assign pre_limit = (7'h01 << pre_sel) - 7'h01;
  assign base_tick = ctl0_reg[`CTL0_CLKSEL] ? alt_tick : 1'b1;
  assign tick = run_reg & base_tick & (pre_reg == pre_limit);
  assign timer_in = ctl1_reg[`CTL1_INSEL] ? event_input : pin_input;
  // Rising edge when polarity is zero, falling edge when one.
  assign edge_det = output_edge_polarity ? (in_prev_reg & ~timer_in) : (~in_prev_reg & timer_in);
  assign is_pwm = operating_mode_select == `MODE_DUAL_PWM;
  assign is_cap = operating_mode_select == `MODE_CAPTURE;
  assign is_caprs = operating_mode_select == `MODE_CAP_RESTART;
  assign cap_evt = run_reg & (is_cap | is_caprs) & edge_det;
  assign reload_hit = tick & (count_reg == reload_reg);
  assign match_hit = tick & (count_reg == match_capture_value_reg);
  // Deadband length is clamped to 128 timer clock ticks.
  assign db_load = (deadband > `DB_MAX) ? `DB_MAX : deadband;

  // Next count: PWM and restart-mode reloads and restart captures go to 0001h.
  always @* begin
    count_next = count_reg;
    if (is_caprs & cap_evt) begin
      count_next = `COUNT_START;
    end else if (reload_hit & (is_pwm | is_caprs)) begin
      count_next = `COUNT_START;
    end else if (tick) begin
      count_next = count_reg + 16'h0001;
    end
  end

  // PWM level: reload restores the polarity level, match toggles.
  always @* begin
    pwm_state_next = pwm_state_reg;
    if (!run_reg) begin
      pwm_state_next = output_edge_polarity;
    end else if (is_pwm & reload_hit) begin
      pwm_state_next = output_edge_polarity;
    end else if (is_pwm & match_hit) begin
      pwm_state_next = ~pwm_state_reg;
    end
  end

  // Input history for the edge detector and the enable, one cycle late.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_prev_reg <= 1'b0;
      run_reg <= 1'b0;
    end else if (pclk_en) begin
      in_prev_reg <= timer_in;
      // Enabling through control one starts counting.
      run_reg <= enable;
    end
  end

  // Prescaler: divides the base tick by a power of two.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg <= 7'h00;
    end else if (pclk_en) begin
      if (run_reg & base_tick) begin
        if (pre_reg == pre_limit) begin
          pre_reg <= 7'h00;
        end else begin
          pre_reg <= pre_reg + 7'h01;
        end
      end
    end
  end

  // Control zero holds the deadband, clock select, interrupt source and top mode bit.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl0_reg <= 16'h0000;
    end else if (pclk_en) begin
      if (wr & (paddr == `OFS_CTL0)) begin
        ctl0_reg <= pwdata[15:0];
      end
    end
  end

  // Control one holds the low mode bits, polarity, prescale, input select and enable.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl1_reg <= 9'h000;
    end else if (pclk_en) begin
      if (wr & (paddr == `OFS_CTL1)) begin
        ctl1_reg <= pwdata[8:0];
      end
    end
  end

  // Reload value written by software.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_reg <= `RELOAD_RESET;
    end else if (pclk_en) begin
      if (wr & (paddr == `OFS_RELOAD)) begin
        reload_reg <= pwdata[15:0];
      end
    end
  end

  // Count: a software write sets the start of the first pass only.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= `COUNT_START;
    end else if (pclk_en) begin
      if (wr & (paddr == `OFS_COUNT)) begin
        count_reg <= pwdata[15:0];
      end else begin
        count_reg <= count_next;
      end
    end
  end

  // Match or capture value: a capture in the same cycle wins over a write.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_capture_value_reg <= `COUNT_RESET;
    end else if (pclk_en) begin
      if (cap_evt) begin
        match_capture_value_reg <= count_reg;
      end else if (wr & (paddr == `OFS_MATCH)) begin
        match_capture_value_reg <= pwdata[15:0];
      end
    end
  end

  // Capture cause flag: set by a capture, cleared by a reload; the set wins.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_cause_flag_reg <= 1'b0;
    end else if (pclk_en) begin
      if (cap_evt) begin
        capture_cause_flag_reg <= 1'b1;
      end else if (reload_hit & (is_cap | is_caprs)) begin
        capture_cause_flag_reg <= 1'b0;
      end
    end
  end

  // Interrupt: a one-cycle pulse per qualifying event.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_irq <= 1'b0;
    end else if (pclk_en) begin
      if (cap_evt) begin
        timer_irq <= interrupt_source_config != `ICFG_RLD_ONLY;
      end else if (reload_hit & (is_cap | is_caprs)) begin
        timer_irq <= interrupt_source_config != `ICFG_CAP_ONLY;
      end else if (reload_hit & is_pwm) begin
        timer_irq <= 1'b1;
      end else begin
        timer_irq <= 1'b0;
      end
    end
  end

  // Internal PWM level before the deadband.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_state_reg <= 1'b0;
    end else if (pclk_en) begin
      pwm_state_reg <= pwm_state_next;
    end
  end

  // Deadband counter: loaded on every level change, counts timer clock ticks.
  always @* begin
    db_cnt_next = db_cnt_reg;
    if (!run_reg) begin
      db_cnt_next = 8'h00;
    end else if (pwm_state_next != pwm_state_reg) begin
      db_cnt_next = db_load;
    end else if ((db_cnt_reg != 8'h00) & base_tick) begin
      db_cnt_next = db_cnt_reg - 8'h01;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      db_cnt_reg <= 8'h00;
    end else if (pclk_en) begin
      db_cnt_reg <= db_cnt_next;
    end
  end

  // Output levels: with a nonzero deadband both drop on a change and the new level shows after the gap.
  always @* begin
    primary_next = pwm_primary_output;
    complement_next = pwm_complement_output;
    if (!run_reg) begin
      primary_next = output_edge_polarity;
      complement_next = is_pwm & ~output_edge_polarity;
    end else if (pwm_state_next != pwm_state_reg) begin
      if (db_load == 8'h00) begin
        primary_next = pwm_state_next;
        complement_next = is_pwm & ~pwm_state_next;
      end else begin
        primary_next = 1'b0;
        complement_next = 1'b0;
      end
    end else if (db_cnt_reg != 8'h00) begin
      if ((db_cnt_reg == 8'h01) & base_tick) begin
        primary_next = pwm_state_reg;
        complement_next = is_pwm & ~pwm_state_reg;
      end
    end else begin
      primary_next = pwm_state_reg;
      complement_next = is_pwm & ~pwm_state_reg;
    end
  end

  // Both outputs come from flip-flops.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_primary_output <= 1'b0;
      pwm_complement_output <= 1'b0;
    end else if (pclk_en) begin
      pwm_primary_output <= primary_next;
      pwm_complement_output <= complement_next;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (pclk_en & rd & ~penable) begin
      case (paddr)
        `OFS_CTL0: begin
          prdata <= {16'h0000, ctl0_reg[15:4], capture_cause_flag_reg, ctl0_reg[2:0]};
        end
        `OFS_CTL1: begin
          prdata <= {23'h000000, ctl1_reg};
        end
        `OFS_COUNT: begin
          prdata <= {16'h0000, count_reg};
        end
        `OFS_RELOAD: begin
          prdata <= {16'h0000, reload_reg};
        end
        `OFS_MATCH: begin
          prdata <= {16'h0000, match_capture_value_reg};
        end
        `OFS_STATUS: begin
          prdata <= {29'h00000000, pwm_complement_output, pwm_primary_output, capture_cause_flag_reg};
        end
        default: begin
          prdata <= 32'h00000000;
        end
      endcase
    end
  end
endmodule // timer_pwm_dual_capture
`default_nettype wire

// [logic/timer_consts.vh]
// Purpose: Register offsets, field positions, reset values and codes for the dual PWM and capture timer.
// Assumes: APB with 32-bit data, one register per aligned word.
// Notes: Definitions only.
`ifndef TIMER_CONSTS_VH
`define TIMER_CONSTS_VH
`define OFS_CTL0 12'h000
`define OFS_CTL1 12'h004
`define OFS_COUNT 12'h008
`define OFS_RELOAD 12'h00c
`define OFS_MATCH 12'h010
`define OFS_STATUS 12'h014
`define CTL0_MODE3 0
`define CTL0_ICFG_LO 1
`define CTL0_ICFG_HI 2
`define CTL0_CAPFLAG 3
`define CTL0_CLKSEL 4
`define CTL0_DB_LO 8
`define CTL0_DB_HI 15
`define CTL1_MODE_LO 0
`define CTL1_MODE_HI 2
`define CTL1_POL 3
`define CTL1_PRE_LO 4
`define CTL1_PRE_HI 6
`define CTL1_INSEL 7
`define CTL1_EN 8
`define MODE_DUAL_PWM 4'h8
`define MODE_CAPTURE 4'h4
`define MODE_CAP_RESTART 4'h9
`define ICFG_CAP_ONLY 2'h2
`define ICFG_RLD_ONLY 2'h3
`define COUNT_START 16'h0001
`define COUNT_RESET 16'h0000
`define RELOAD_RESET 16'hffff
`define DB_MAX 8'h80
`endif

// [tb/timer_properties.sv]
// Purpose: Port checks for the timer.
// Assumes: Sees only the top module ports.
// Notes: One clock domain.
`default_nettype none
module timer_properties (
  // Clock and reset.
  input wire logic pclk,
  input wire logic pclk_en,
  input wire logic presetn,
  // APB.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Outputs.
  input wire logic pwm_primary_output,
  input wire logic pwm_complement_output,
  input wire logic timer_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_bad; psel && penable && (paddr > 12'h014 || paddr[1:0] != 2'h0); endsequence
  sequence s_rd; psel && penable && !pwrite; endsequence
  property p_gap; !(pwm_primary_output && pwm_complement_output); endproperty
  a_gap: assert property (p_gap) else $error("outputs overlap");
  property p_err; s_bad |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("no slave error");
  property p_ok; psel && penable && paddr <= 12'h014 && paddr[1:0] == 2'h0 |-> pready && !pslverr; endproperty
  a_ok: assert property (p_ok) else $error("bad response");
  property p_zero; s_bad ##0 s_rd |-> prdata == 32'h0; endproperty
  a_zero: assert property (p_zero) else $error("unmapped read not zero");
  property p_hold; s_rd |=> $stable(prdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_frz_p; !pclk_en |=> $stable(pwm_primary_output); endproperty
  a_frz_p: assert property (p_frz_p) else $error("primary moved");
  property p_frz_c; !pclk_en |=> $stable(pwm_complement_output); endproperty
  a_frz_c: assert property (p_frz_c) else $error("complement moved");
  property p_frz_i; !pclk_en |=> $stable(timer_irq); endproperty
  a_frz_i: assert property (p_frz_i) else $error("irq moved");
endmodule // timer_properties
bind timer_pwm_dual_capture timer_properties u_props (.pclk, .pclk_en, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .pwm_primary_output, .pwm_complement_output, .timer_irq);
`default_nettype wire

// [tb/far_side_model.sv]
// Purpose: Pin and event routing for input zero, plus the alternate tick.
// Assumes: Bench sets level and use_event.
// Notes: The unselected line toggles every cycle.
`default_nettype none
module far_side_model #(
  parameter int ALT_DIV = 3
) (
  // Clock.
  input wire logic pclk,
  // Bench control.
  input wire logic level,
  input wire logic use_event,
  // Towards the timer.
  output logic pin_input,
  output logic event_input,
  output logic alt_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  int div = 0;
  logic pat = 1'b0;
  initial {pin_input, event_input, alt_tick} = 3'h0;
  always @(posedge pclk) begin
    div <= (div == ALT_DIV - 1) ? 0 : div + 1;
    alt_tick <= (div == 0);
    pat <= ~pat;
    pin_input <= use_event ? pat : level;
    event_input <= use_event ? level : pat;
  end
endmodule // far_side_model
`default_nettype wire

// [tb/tb_top.sv]
// Purpose: Self-checking bench for the timer.
// Assumes: Alternate tick every third cycle.
// Notes: Random values from an xorshift seeded with 61.
`include "timer_consts.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, pclk_en = 1'b1, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic level = 1'b0, use_event = 1'b0, pready, pslverr, pin_input, event_input, alt_tick;
  logic pwm_primary_output, pwm_complement_output, timer_irq;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, q, seed = 32'h3d;
  int err_count = 0, num_checks = 0, irq_n = 0;
  logic [11:0] ra [6] = '{`OFS_CTL0, `OFS_CTL1, `OFS_COUNT, `OFS_RELOAD, `OFS_MATCH, 12'h018};
  logic [31:0] rv [6] = '{32'h0, 32'h0, 32'h1, 32'hffff, 32'h0, 32'h0};
  timer_pwm_dual_capture u_dut (.pclk, .pclk_en, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .alt_tick, .pin_input, .event_input, .pwm_primary_output, .pwm_complement_output, .timer_irq);
  far_side_model u_far (.pclk, .level, .use_event, .pin_input, .event_input, .alt_tick);
  initial forever #4 pclk = ~pclk;
  always @(posedge pclk) if (timer_irq === 1'b1) irq_n++;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int exp_high(input logic pol, input int r, input int m, input int f);
    return pol ? m * f : (r - m) * f;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      $display("Error %s expected %h seen %h", nm, e, s);
      err_count++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    {psel, penable} <= 2'b00;
  endtask
  task automatic wait_irq();
    do @(negedge pclk); while (timer_irq !== 1'b1);
  endtask
  task automatic pwm(input logic pol, input logic [2:0] pre, input logic cs, input logic [15:0] r, m,
    input logic [7:0] d);
    int f, de, hp, lo, n, e;
    f = (1 << pre) * (cs ? 3 : 1);
    de = ((d > 128) ? 128 : d) * (cs ? 3 : 1);
    hp = 0;
    lo = 0;
    n = 0;
    apb(1, `OFS_CTL1, {24'h0, 1'b0, pre, pol, 3'h0});
    apb(1, `OFS_CTL0, {16'h0, d, 3'h0, cs, 4'h1});
    apb(1, `OFS_COUNT, 32'h3);
    apb(1, `OFS_MATCH, {16'h0, m});
    apb(1, `OFS_RELOAD, {16'h0, r});
    apb(1, `OFS_CTL1, {24'h1, 1'b0, pre, pol, 3'h0});
    wait_irq();
    wait_irq();
    do begin
      @(negedge pclk);
      n++;
      hp += pwm_primary_output;
      lo += !pwm_primary_output && !pwm_complement_output;
    end while (timer_irq !== 1'b1);
    e = exp_high(pol, r, m, f);
    chk("period", r * f, n);
    chk("high time", 1, hp + de - e <= f + 2 && e - hp - de <= f + 2);
    chk("gap", 1, lo >= 2 * de && lo <= 2 * de + 2);
    @(posedge pclk);
    pclk_en <= 1'b0;
    repeat (4) @(posedge pclk);
    pclk_en <= 1'b1;
    $display("test pwm done");
  endtask
  task automatic cap(input logic [3:0] md, input logic [1:0] ic);
    logic pol, s;
    int n0;
    logic [15:0] mv;
    pol = 1'(rnd());
    s = 1'(rnd());
    level <= pol;
    use_event <= s;
    apb(1, `OFS_CTL1, {24'h0, s, 3'h0, pol, md[2:0]});
    apb(1, `OFS_CTL0, {28'h0, 1'b0, ic, md[3]});
    apb(1, `OFS_COUNT, 32'h1);
    apb(1, `OFS_RELOAD, 32'h50);
    apb(1, `OFS_MATCH, 32'h0);
    apb(1, `OFS_CTL1, {24'h1, s, 3'h0, pol, md[2:0]});
    repeat (20) @(posedge pclk);
    n0 = irq_n;
    level <= !pol;
    repeat (10) @(posedge pclk);
    level <= pol;
    chk("capture irq", ic != `ICFG_RLD_ONLY, irq_n - n0);
    apb(0, `OFS_MATCH, 32'h0);
    mv = q[15:0];
    chk("capture value", 1, q >= 32'd20 && q <= 32'd28);
    apb(0, `OFS_CTL0, 32'h0);
    chk("flag set", 1, q[3]);
    apb(0, `OFS_COUNT, 32'h0);
    chk("count", 1, md == `MODE_CAP_RESTART ? q < 32'd32 : q > {16'h0, mv});
    n0 = irq_n;
    repeat (90) @(posedge pclk);
    chk("reload irq", ic != `ICFG_CAP_ONLY, irq_n - n0);
    apb(0, `OFS_CTL0, 32'h0);
    chk("flag clear", 0, q[3]);
    $display("test capture done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    logic [15:0] r;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(0, ra[i], 32'h0);
      chk("reset value", rv[i], q);
    end
    $display("test reset done");
    pwm(1'b1, 3'h0, 1'b0, 16'd300, 16'd150, 8'hff);
    pwm(1'b0, 3'h1, 1'b1, 16'd20, 16'd5, 8'h0);
    for (int i = 0; i < 4; i++) begin
      r = 16'(rnd() % 40 + 24);
      pwm(1'(rnd()), 3'(rnd() % 2), 1'(rnd()), r, 16'(r / 4 + rnd() % (r / 2)), 8'(rnd() % 4));
    end
    cap(`MODE_CAPTURE, 2'h0);
    cap(`MODE_CAP_RESTART, 2'h1);
    cap(`MODE_CAPTURE, `ICFG_RLD_ONLY);
    cap(`MODE_CAP_RESTART, `ICFG_CAP_ONLY);
    summarize();
  end
  initial begin
    #400000;
    err_count++;
    summarize();
  end
endmodule // tb_top
`default_nettype wire
